/* rtl/anps_regs.sv */
/*
 * Auto-negotiation partner status register bank: the partner technology
 * and selector portion of the partner ability register and the expansion
 * register with its latching and live flags.
 * Assumes the serial management framing lives outside and presents one
 * request per cycle; negotiation events arrive as core-clock pulses.
 */
// Notes on behaviour
// - Partner technology bits load from received word
// - Reserved partner technology positions read zero
// - Selector shows received code; any five-bit value
// - Decode Ethernet and integrated-services selector codes
// - Expansion bits fifteen to five read zero
// - Override-write bits writable only under override
// - Set fault flag on undetermined partner technology
// - Fault flag latches until expansion read
// - Partner next-page flag follows received word
// - Local next-page-able flag always reads one
// - Page received flag sets on stored word
// - Expansion read clears page received flag
// - Partner negotiation-able flag sets on valid bursts
`timescale 1ns/1ps
`default_nettype none

module anps_regs
	import anps_pkg::*;
(
	input  wire logic        i_core_clk,     // Core clock, 20 MHz
	input  wire logic        i_arst_n,       // Async reset, active low
	input  wire anps_mreq_t  i_mreq,         // Management register request
	input  wire logic        i_cmd_override, // Command override bit
	input  wire logic        i_lcw_valid,    // Received word stored pulse
	input  wire logic [15:0] i_lcw,          // Received link code word
	input  wire logic        i_pd_fault,     // Parallel detection fault pulse
	input  wire logic        i_flp_ok,       // Valid burst seen pulse
	input  wire logic        i_an_restart,   // Negotiation restart pulse
	output logic [15:0]      o_rdata,        // Read data
	output logic             o_rd_valid,     // Read data valid pulse
	output logic [3:0]       o_partner_tech, // Partner technology bits
	output logic             o_sel_ethernet, // Partner selector is Ethernet
	output logic             o_sel_isdn,     // Partner selector is ISDN std
	output logic [10:0]      o_aux_bits      // Hidden override-write bits
);

	logic        rst_meta_q;   // Reset synchroniser stage one
	logic        rst_n_q;      // Synchronised reset
	logic [3:0]  tech_q;       // Partner technology bits
	logic [4:0]  sel_q;        // Partner selector field
	logic        lp_np_q;      // Partner next-page-able
	logic        lp_an_q;      // Partner negotiation-able
	logic [10:0] aux_q;        // Override-write storage
	logic        pd_fault_q;   // Latched parallel fault
	logic        page_rcvd_q;  // Latched page received
	logic        rd_exp;       // Read of expansion register
	logic        wr_partner;   // Override write to partner register
	logic        wr_exp;       // Override write to expansion register
	logic [15:0] partner_view; // Partner register read image
	logic [15:0] exp_view;     // Expansion register read image

	// Reset release through two flip-flops
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// Access decode
	assign rd_exp     = i_mreq.rd && (i_mreq.addr == ANPS_OFS_EXPANSN);
	assign wr_partner = i_mreq.wr && i_cmd_override
		&& (i_mreq.addr == ANPS_OFS_PARTNER);
	assign wr_exp     = i_mreq.wr && i_cmd_override
		&& (i_mreq.addr == ANPS_OFS_EXPANSN);

	// Partner technology bits follow each stored word
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tech_q <= ANPS_TECH_RESET;
		end else if (i_lcw_valid) begin
			tech_q <= i_lcw[ANPS_P_TECH_HI:ANPS_P_TECH_LO];
		end
	end

	// Selector: received code, low bits writable under override
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sel_q <= ANPS_SEL_RESET;
		end else if (i_lcw_valid) begin
			sel_q <= i_lcw[ANPS_P_SEL_HI:0];
		end else if (wr_partner) begin
			sel_q[ANPS_P_CW_SEL_HI:0] <=
				i_mreq.wdata[ANPS_P_CW_SEL_HI:0];
		end
	end

	// Partner next-page-able tracks the received word
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lp_np_q <= 1'b0;
		end else if (i_lcw_valid) begin
			lp_np_q <= i_lcw[ANPS_P_NP_BIT];
		end
	end

	// Partner negotiation-able: set by bursts, dropped on restart
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lp_an_q <= 1'b0;
		end else if (i_flp_ok) begin
			lp_an_q <= 1'b1;
		end else if (i_an_restart) begin
			lp_an_q <= 1'b0;
		end
	end

	// Hidden override-write storage behind reserved expansion bits
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			aux_q <= ANPS_AUX_RESET;
		end else if (wr_exp) begin
			aux_q <= i_mreq.wdata[ANPS_X_RESV_HI:ANPS_X_RESV_LO];
		end
	end

	// Parallel detection fault, latching high
	anps_sticky u_pd_fault (
		.i_core_clk (i_core_clk),
		.i_rst_n    (rst_n_q),
		.i_set      (i_pd_fault),
		.i_clr      (rd_exp),
		.o_flag     (pd_fault_q)
	);

	// Page received, latching high
	anps_sticky u_page_rcvd (
		.i_core_clk (i_core_clk),
		.i_rst_n    (rst_n_q),
		.i_set      (i_lcw_valid),
		.i_clr      (rd_exp),
		.o_flag     (page_rcvd_q)
	);

	// Read images; reserved and omitted bits read zero
	always_comb begin
		partner_view = ANPS_ZERO16;
		partner_view[ANPS_P_TECH_HI:ANPS_P_TECH_LO] = tech_q;
		partner_view[ANPS_P_SEL_HI:0] = sel_q;
		exp_view = ANPS_EXP_RESET;
		exp_view[ANPS_X_PD_FAULT]    = pd_fault_q;
		exp_view[ANPS_X_LP_NP_ABLE]  = lp_np_q;
		exp_view[ANPS_X_PAGE_RCVD]   = page_rcvd_q;
		exp_view[ANPS_X_LP_AN_ABLE]  = lp_an_q;
	end

	// Read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_rdata    <= ANPS_ZERO16;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_mreq.rd;
			if (i_mreq.rd) begin
				case (i_mreq.addr)
					ANPS_OFS_PARTNER: begin
						o_rdata <= partner_view;
					end
					ANPS_OFS_EXPANSN: begin
						o_rdata <= exp_view;
					end
					default: begin
						o_rdata <= ANPS_ZERO16;
					end
				endcase
			end
		end
	end

	// Selector decode of the Ethernet and integrated-services codes
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_sel_ethernet <= 1'b0;
			o_sel_isdn     <= 1'b0;
		end else begin
			o_sel_ethernet <= (sel_q == ANPS_SEL_ETHERNET);
			o_sel_isdn     <= (sel_q == ANPS_SEL_ISDN);
		end
	end

	assign o_partner_tech = tech_q;
	assign o_aux_bits     = aux_q;

	// Checks
	tech_load_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		i_lcw_valid |=> o_partner_tech == $past(i_lcw[8:5]))
		else $error("partner technology not loaded");
	resv_zero_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		i_mreq.rd && i_mreq.addr == 5'h05 |=> o_rd_valid && o_rdata[12:10] == 3'h0)
		else $error("partner reserved bits not zero");
	sel_load_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		i_lcw_valid ##1 (i_mreq.rd && i_mreq.addr == 5'h05)
		|=> o_rdata[4:0] == $past(i_lcw[4:0], 2))
		else $error("selector not shown");
	sel_decode_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		1'b1 |=> ((o_sel_ethernet == ($past(sel_q) == 5'h01))
			&& (o_sel_isdn == ($past(sel_q) == 5'h02))))
		else $error("selector decode wrong");
	exp_resv_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		rd_exp |=> o_rdata[15:5] == 11'h000 && o_rdata[2])
		else $error("expansion reserved or local bit wrong");
	cw_block_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		i_mreq.wr && !i_cmd_override && !i_lcw_valid |=> $stable(sel_q) && $stable(aux_q))
		else $error("override-write bits changed without override");
	pdf_latch_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		i_pd_fault ##1 !rd_exp[*3] |-> pd_fault_q)
		else $error("fault flag not held");
	np_track_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		i_lcw_valid |=> lp_np_q == $past(i_lcw[15]))
		else $error("partner next-page flag wrong");
	pr_clear_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		rd_exp && !i_lcw_valid |=> !page_rcvd_q)
		else $error("page received not cleared by read");
	set_wins_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		rd_exp && i_pd_fault |=> pd_fault_q)
		else $error("event lost against clear");
	pr_set_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		i_lcw_valid |=> page_rcvd_q)
		else $error("page received not set");
	pdf_set_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		i_pd_fault |=> pd_fault_q)
		else $error("fault flag not set");
	an_able_a: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
		i_flp_ok |=> lp_an_q)
		else $error("partner negotiation-able not set");

	load_then_read_c: cover property (@(posedge i_core_clk) disable iff (!rst_n_q)
		i_lcw_valid ##[1:4] rd_exp);
	clash_c: cover property (@(posedge i_core_clk) disable iff (!rst_n_q)
		rd_exp && i_lcw_valid);
	override_wr_c: cover property (@(posedge i_core_clk) disable iff (!rst_n_q)
		wr_partner);

endmodule

`default_nettype wire

/* rtl/anps_pkg.sv */
/*
 * Shared constants and types for the auto-negotiation partner status
 * register bank: register offsets, field positions, reset values and the
 * management request carrier.
 * Assumes a single core clock domain; no timing counts are needed.
 */
package anps_pkg;

	// Register offsets on the management register port
	localparam logic [4:0]  ANPS_OFS_PARTNER  = 5'h05;
	localparam logic [4:0]  ANPS_OFS_EXPANSN  = 5'h06;

	// Partner ability register field positions
	localparam int          ANPS_P_NP_BIT     = 15;
	localparam int          ANPS_P_RESV_HI    = 12;
	localparam int          ANPS_P_RESV_LO    = 10;
	localparam int          ANPS_P_TECH_HI    = 8;
	localparam int          ANPS_P_TECH_LO    = 5;
	localparam int          ANPS_P_SEL_HI     = 4;
	localparam int          ANPS_P_CW_SEL_HI  = 3;

	// Expansion register field positions
	localparam int          ANPS_X_RESV_HI    = 15;
	localparam int          ANPS_X_RESV_LO    = 5;
	localparam int          ANPS_X_PD_FAULT   = 4;
	localparam int          ANPS_X_LP_NP_ABLE = 3;
	localparam int          ANPS_X_NP_ABLE    = 2;
	localparam int          ANPS_X_PAGE_RCVD  = 1;
	localparam int          ANPS_X_LP_AN_ABLE = 0;

	// Selector codes
	localparam logic [4:0]  ANPS_SEL_ETHERNET = 5'h01;
	localparam logic [4:0]  ANPS_SEL_ISDN     = 5'h02;

	// Reset values
	localparam logic [15:0] ANPS_EXP_RESET    = 16'h0004;
	localparam logic [4:0]  ANPS_SEL_RESET    = 5'h00;
	localparam logic [3:0]  ANPS_TECH_RESET   = 4'h0;
	localparam logic [10:0] ANPS_AUX_RESET    = 11'h000;
	localparam logic [15:0] ANPS_ZERO16       = 16'h0000;

	// Management register request, one cycle per access
	typedef struct packed {
		logic        rd;     // Read strobe
		logic        wr;     // Write strobe
		logic [4:0]  addr;   // Register number
		logic [15:0] wdata;  // Write data
	} anps_mreq_t;

endpackage

/* rtl/anps_sticky.sv */
/*
 * One latching-high status flag: set by a hardware event, cleared by a
 * management read, with the event winning when both land together.
 * Assumes a synchronised active-low reset from the instantiating module.
 */
`timescale 1ns/1ps
`default_nettype none

module anps_sticky (
	input  wire logic i_core_clk,  // Core clock
	input  wire logic i_rst_n,     // Synchronised reset
	input  wire logic i_set,       // Event pulse
	input  wire logic i_clr,       // Clear-on-read pulse
	output logic      o_flag       // Latched flag
);

	// Set dominates clear so a coinciding event is kept
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_flag <= 1'b0;
		end else if (i_set) begin
			o_flag <= 1'b1;
		end else if (i_clr) begin
			o_flag <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* bench/anps_sta_model.sv */
/*
 * Management entity model: issues one-cycle register reads and writes
 * to the partner status bank and returns what the bank answers.
 * Assumes each task is called just after a falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module anps_sta_model
	import anps_pkg::*;
(
	input  wire logic        i_core_clk, // Core clock
	input  wire logic [15:0] i_rdata,    // Read data from the bank
	input  wire logic        i_rd_valid, // Read answer strobe
	output var  anps_mreq_t  o_mreq      // Request to the bank
);
	// Idle request from time zero
	initial begin
		o_mreq = '0;
	end

	// Read: strobe one cycle, take the answer while its strobe stands
	task automatic rd(input logic [4:0] a, output logic [15:0] d,
		output logic v);
		o_mreq.addr = a;
		o_mreq.rd = 1'h1;
		@(negedge i_core_clk);
		d = i_rdata;
		v = i_rd_valid;
		o_mreq.rd = 1'h0;
		@(negedge i_core_clk);
	endtask

	// Write: reserved bits always carry their default of zero
	task automatic wr(input logic [4:0] a, input logic [4:0] sel);
		o_mreq.addr = a;
		o_mreq.wdata = {ANPS_AUX_RESET, sel};
		o_mreq.wr = 1'h1;
		@(negedge i_core_clk);
		o_mreq.wr = 1'h0;
		// Let an edge pass so a following write is a fresh strobe
		@(negedge i_core_clk);
	endtask
endmodule

`default_nettype wire

/* bench/anps_regs_tb_top.sv */
/*
 * Self-checking bench for the partner status register bank.
 * Assumes the management entity model drives all register requests.
 */
`timescale 1ns/1ps
`default_nettype none

module anps_regs_tb_top;
	import anps_pkg::*;
	logic        core_clk;        // Core clock
	logic        arst_n;          // Reset, active low
	anps_mreq_t  mreq;            // Register request
	logic        cmd_override;    // Override level
	logic        lcw_valid;       // Word stored pulse
	logic [15:0] lcw;             // Received word
	logic        pd_fault;        // Fault event pulse
	logic        flp_ok;          // Burst event pulse
	logic        an_restart;      // Restart pulse
	logic [15:0] rdata;           // Read data
	logic        rd_valid;        // Read answer strobe
	logic [3:0]  partner_tech;    // Technology bits
	logic        sel_eth;         // Ethernet selector
	logic        sel_isdn;        // Integrated-services selector
	logic [10:0] aux_bits;        // Hidden bits
	int          n_mismatch;      // Mismatch count
	int          samples_checked; // Comparison count
	int          cycles;          // Timeout counter

	anps_regs anps_regs_i (.i_core_clk(core_clk), .i_arst_n(arst_n),
		.i_mreq(mreq), .i_cmd_override(cmd_override),
		.i_lcw_valid(lcw_valid), .i_lcw(lcw), .i_pd_fault(pd_fault),
		.i_flp_ok(flp_ok), .i_an_restart(an_restart), .o_rdata(rdata),
		.o_rd_valid(rd_valid), .o_partner_tech(partner_tech),
		.o_sel_ethernet(sel_eth), .o_sel_isdn(sel_isdn),
		.o_aux_bits(aux_bits));
	anps_sta_model anps_sta_model_i (.i_core_clk(core_clk),
		.i_rdata(rdata), .i_rd_valid(rd_valid), .o_mreq(mreq));

	// Clock, 50 ns period
	initial begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end

	// Cut a hang short
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	// Counts line, verdict, end of run
	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", n_mismatch,
			samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Compare one register word
	task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask

	// Compare one flag or small field
	task automatic chk4(string nm, logic [3:0] e, logic [3:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask

	// Read a register and compare word and answer strobe
	task automatic rdc(logic [4:0] a, logic [15:0] e);
		logic [15:0] d;
		logic        v;
		anps_sta_model_i.rd(a, d, v);
		chk4("read strobe", 4'h1, {3'h0, v});
		chk16("read data", e, d);
	endtask

	// Pulse one event input for a cycle
	task automatic word_in(logic [15:0] w);
		lcw = w;
		lcw_valid = 1'h1;
		@(negedge core_clk);
		lcw_valid = 1'h0;
	endtask

	// Defaults after reset, unmapped offset
	task automatic t_reset();
		rdc(ANPS_OFS_EXPANSN, ANPS_EXP_RESET);
		rdc(ANPS_OFS_PARTNER, ANPS_ZERO16);
		rdc(5'h07, ANPS_ZERO16);
	endtask

	// Received word with reserved and next-page bits set
	task automatic t_word();
		word_in(16'h9DE1);
		rdc(ANPS_OFS_PARTNER, 16'h01E1);
		chk4("tech", 4'hF, partner_tech);
		chk4("eth", 4'h1, {3'h0, sel_eth});
		rdc(ANPS_OFS_EXPANSN, 16'h000E);
		rdc(ANPS_OFS_EXPANSN, 16'h000C);
	endtask

	// Selector codes one to three decoded
	task automatic t_sel();
		logic [4:0] c;
		for (int i = 1; i <= 3; i++) begin
			c = i[4:0];
			word_in({11'h000, c});
			@(negedge core_clk);
			@(negedge core_clk);
			chk4("eth", {3'h0, c == 5'h01}, {3'h0, sel_eth});
			chk4("isdn", {3'h0, c == 5'h02}, {3'h0, sel_isdn});
		end
		rdc(ANPS_OFS_EXPANSN, 16'h0006);
	endtask

	// Fault and burst flags, restart
	task automatic t_flags();
		pd_fault = 1'h1;
		flp_ok = 1'h1;
		@(negedge core_clk);
		pd_fault = 1'h0;
		flp_ok = 1'h0;
		rdc(ANPS_OFS_EXPANSN, 16'h0015);
		rdc(ANPS_OFS_EXPANSN, 16'h0005);
		an_restart = 1'h1;
		@(negedge core_clk);
		an_restart = 1'h0;
		rdc(ANPS_OFS_EXPANSN, 16'h0004);
	endtask

	// Fault event in the cycle of a clearing read
	task automatic t_race();
		pd_fault = 1'h1;
		fork
			rdc(ANPS_OFS_EXPANSN, 16'h0004);
			begin
				@(negedge core_clk);
				pd_fault = 1'h0;
			end
		join
		rdc(ANPS_OFS_EXPANSN, 16'h0014);
		rdc(ANPS_OFS_EXPANSN, 16'h0004);
	endtask

	// Selector writes blocked, then taken under override
	task automatic t_ovr();
		anps_sta_model_i.wr(ANPS_OFS_PARTNER, 5'h01);
		rdc(ANPS_OFS_PARTNER, 16'h0003);
		cmd_override = 1'h1;
		anps_sta_model_i.wr(ANPS_OFS_PARTNER, 5'h02);
		rdc(ANPS_OFS_PARTNER, 16'h0002);
		chk4("isdn", 4'h1, {3'h0, sel_isdn});
		anps_sta_model_i.wr(ANPS_OFS_EXPANSN, 5'h00);
		rdc(ANPS_OFS_EXPANSN, 16'h0004);
		chk16("aux", 16'h0000, {5'h00, aux_bits});
	endtask

	// Main sequence; partner contents read at reset and after stored words
	initial begin
		{cmd_override, lcw_valid, pd_fault, flp_ok, an_restart} = '0;
		lcw = '0;
		n_mismatch = 0;
		samples_checked = 0;
		cycles = 0;
		arst_n = 1'h0;
		repeat (2) @(negedge core_clk);
		arst_n = 1'h1;
		repeat (4) @(negedge core_clk);
		t_reset();
		t_word();
		t_sel();
		t_flags();
		t_race();
		t_ovr();
		wrap_up();
	end
endmodule

`default_nettype wire
